// ---- cfg_mirror_pkg.sv ----
/*
  Constants, field layouts and helper functions for the configuration space mirror.
  Assumes one application clock; the core's configuration store drives this block from that same clock.
*/
// Operation
// - Root Port only: 44-bit prefetchable limit upper bits output, zero otherwise.
// - 32-bit power management output: control in [31:16], status in [15:0].
// - Two 16-bit outputs mirror MSI and MSI-X message control.
// - Map entry for traffic class 0, bits [2:0], is always zero.
// - Entries for classes 1 to 7 fill ascending 3-bit groups, 5:3 to 23:21.
// - 16-bit output carries the programmed MSI message data.
// - 13-bit output carries bus/device number, captured or programmed.
// - MSI control bit 8, per-vector masking capable, always reads zero.
// - MSI control bit 7 reports 64-bit message address capability.
// - Multiple message enable [6:4] codes 0 to 5 allocate 1 to 32 vectors.
// - MSI control bit 0 enables MSI; no MSI issues while it is zero.
// - Multiple message capable [3:1] shows requested vectors, same encoding.
// - 64-bit MSI address is output as lower and upper 32-bit halves.
`default_nettype none
package cfg_mirror_pkg;
  localparam logic [11:0] MSI_CTRL_OFFSET = 12'h050;
  localparam logic [11:0] MSIX_CTRL_OFFSET = 12'h068;
  localparam logic [11:0] PMCSR_OFFSET = 12'h07c;
  localparam int CFG_ADDR_W = 12;
  localparam int CFG_DATA_W = 32;
  localparam int CFG_BE_W = 4;
  // The message control word sits in the upper half of its capability dword.
  localparam int CTRL_HALF_LSB = 16;
  localparam int CTRL_LO_LANE = 2;
  localparam int CTRL_HI_LANE = 3;
  localparam int CTRL_W = 16;
  localparam int MSI_EN_BIT = 0;
  localparam int MMC_LSB = 1;
  localparam int MME_LSB = 4;
  localparam int MME_W = 3;
  localparam int ADDR64_BIT = 7;
  localparam int MASKCAP_BIT = 8;
  localparam int MSI_RSVD_LSB = 9;
  localparam int MSI_RSVD_W = 7;
  localparam int MSIX_EN_BIT = 15;
  localparam int MSIX_FMASK_BIT = 14;
  localparam int MSIX_TSIZE_W = 11;
  localparam int MSIX_RSVD_W = 3;
  localparam logic [MME_W-1:0] MME_LAST = 3'h5;
  localparam logic [MME_W-1:0] MME_RST = 3'h0;
  localparam int PR_LIM_W = 44;
  localparam int PMCSR_W = 32;
  localparam int PM_HALF_W = 16;
  localparam int TC_ENTRY_W = 3;
  localparam int TC_COUNT = 8;
  localparam int TCVC_W = 24;
  localparam int MSI_DATA_W = 16;
  localparam int ADDR_HALF_W = 32;
  localparam int BUSDEV_W = 13;
  localparam int VEC_CNT_W = 6;
  localparam int VEC_IDX_W = 5;
  localparam logic [VEC_CNT_W-1:0] VEC_ONE = 6'h01;

  // Number of vectors a multiple-message code stands for.
  function automatic logic [VEC_CNT_W-1:0] vecCount(input logic [MME_W-1:0] code);
    return VEC_ONE << code;
  endfunction : vecCount
endpackage : cfg_mirror_pkg
`default_nettype wire

// ---- msi_issue_gate.sv ----
/*
  Gate for MSI issue requests from the application side.
  Assumes requests come from logic on ref_clk and the enable and allocation come from the mirror.
*/
`timescale 1ns/1ps
`default_nettype none
module msi_issue_gate
  import cfg_mirror_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic msiEnable,
  input wire logic [MME_W-1:0] msgEnableCode,
  input wire logic issueReq,
  input wire logic [VEC_IDX_W-1:0] issueVector,
  output var logic issueGrant_q,
  output var logic [VEC_IDX_W-1:0] grantVector_q,
  output var logic issueRefused_q
);
  logic [VEC_CNT_W-1:0] allocated;
  logic vectorInRange;
  logic grantNow;

  // A vector beyond the allocation is refused rather than aliased, so a missing interrupt shows.
  assign allocated = vecCount(msgEnableCode);
  assign vectorInRange = {1'b0, issueVector} < allocated;
  assign grantNow = issueReq && msiEnable && vectorInRange;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      issueGrant_q <= 1'b0;
      grantVector_q <= '0;
      issueRefused_q <= 1'b0;
    end else begin
      issueGrant_q <= grantNow;
      grantVector_q <= grantNow ? issueVector : grantVector_q;
      issueRefused_q <= issueReq && !grantNow;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_no_msi_disabled: assert property (!msiEnable |=> !issueGrant_q) else $error("MSI granted while disabled");
  chk_grant_in_range: assert property (issueGrant_q |-> {1'b0, grantVector_q} < $past(allocated))
    else $error("Granted vector outside allocation");
  chk_req_answered: assert property (issueReq |=> (issueGrant_q ^ issueRefused_q))
    else $error("Request neither granted nor refused");
  cov_grant: cover property (issueReq ##1 issueGrant_q);
endmodule : msi_issue_gate
`default_nettype wire

// ---- cfg_space_mirror.sv ----
/*
  Configuration space mirror: copies core configuration values onto application-side buses,
  owns the writable MSI and MSI-X message control bits and answers configuration reads of them.
  Assumes the configuration access port and core inputs run on ref_clk; no crossing is needed.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_space_mirror
  import cfg_mirror_pkg::*;
#(
  parameter logic [MME_W-1:0] MSG_CAPABLE_CODE = 3'h5,
  parameter logic ADDR64_CAPABLE = 1'b1
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rootPortMode,
  input wire logic cfgWrEn,
  input wire logic [CFG_ADDR_W-1:0] cfgWrAddr,
  input wire logic [CFG_DATA_W-1:0] cfgWrData,
  input wire logic [CFG_BE_W-1:0] cfgWrBe,
  input wire logic cfgRdEn,
  input wire logic [CFG_ADDR_W-1:0] cfgRdAddr,
  input wire logic [PR_LIM_W-1:0] prefetchLimitIn,
  input wire logic [PM_HALF_W-1:0] pmControlIn,
  input wire logic [PM_HALF_W-1:0] pmStatusIn,
  input wire logic [MSIX_TSIZE_W-1:0] msixTableSize,
  input wire logic [TCVC_W-TC_ENTRY_W-1:0] tcMapUpperIn,
  input wire logic [MSI_DATA_W-1:0] msiDataIn,
  input wire logic [ADDR_HALF_W-1:0] msiAddrLoIn,
  input wire logic [ADDR_HALF_W-1:0] msiAddrHiIn,
  input wire logic [BUSDEV_W-1:0] capturedBusDev,
  input wire logic [BUSDEV_W-1:0] programmedBusDev,
  input wire logic programmedBusDevValid,
  input wire logic issueReq,
  input wire logic [VEC_IDX_W-1:0] issueVector,
  output var logic [PR_LIM_W-1:0] prefetch_limit_upper_q,
  output var logic [PMCSR_W-1:0] pmCtrlStatus_q,
  output var logic [CTRL_W-1:0] msiCtrl_q,
  output var logic [CTRL_W-1:0] msixCtrl_q,
  output var logic [TCVC_W-1:0] tcVcMap_q,
  output var logic [MSI_DATA_W-1:0] msiData_q,
  output var logic [ADDR_HALF_W-1:0] msiAddrLo_q,
  output var logic [ADDR_HALF_W-1:0] msiAddrHi_q,
  output var logic [BUSDEV_W-1:0] busDevNum_q,
  output var logic [VEC_CNT_W-1:0] msiVectorsAllocated_q,
  output var logic [CFG_DATA_W-1:0] cfgRdData_q,
  output var logic cfgRdValid_q,
  output var logic issueGrant_q,
  output var logic [VEC_IDX_W-1:0] grantVector_q,
  output var logic issueRefused_q
);
  logic msiEn_q;
  logic [MME_W-1:0] mme_q;
  logic msixEn_q;
  logic msixFmask_q;

  wire logic [CTRL_W-1:0] ctrlWrWord;
  wire logic wrMsiLo;
  wire logic wrMsixHi;
  wire logic [MME_W-1:0] mmeWr;
  wire logic mmeLegal;
  wire logic msiEn_d;
  wire logic [MME_W-1:0] mme_d;
  wire logic msixEn_d;
  wire logic msixFmask_d;
  wire logic [CTRL_W-1:0] msiCtrlWord;
  wire logic [CTRL_W-1:0] msixCtrlWord;
  wire logic [PR_LIM_W-1:0] prefetchLimit_d;
  wire logic [TCVC_W-1:0] tcVcMap_d;
  wire logic [BUSDEV_W-1:0] busDev_d;
  wire logic rdMsi;
  wire logic rdMsix;
  wire logic rdPm;
  wire logic [CFG_DATA_W-1:0] rdData_d;

  // Write decode. Only byte lanes that carry writable bits matter; other lanes are read-only here.
  assign ctrlWrWord = cfgWrData[CTRL_HALF_LSB +: CTRL_W];
  assign wrMsiLo = cfgWrEn && (cfgWrAddr == MSI_CTRL_OFFSET) && cfgWrBe[CTRL_LO_LANE];
  assign wrMsixHi = cfgWrEn && (cfgWrAddr == MSIX_CTRL_OFFSET) && cfgWrBe[CTRL_HI_LANE];
  assign mmeWr = ctrlWrWord[MME_LSB +: MME_W];
  // Reserved allocation codes are dropped so the vector count always stays defined.
  assign mmeLegal = mmeWr <= MME_LAST;
  assign msiEn_d = wrMsiLo ? ctrlWrWord[MSI_EN_BIT] : msiEn_q;
  assign mme_d = (wrMsiLo && mmeLegal) ? mmeWr : mme_q;
  assign msixEn_d = wrMsixHi ? ctrlWrWord[MSIX_EN_BIT] : msixEn_q;
  assign msixFmask_d = wrMsixHi ? ctrlWrWord[MSIX_FMASK_BIT] : msixFmask_q;

  // Control word images. MSI bits 15:9 and the mask capability bit are constant zero, so writes cannot reach them.
  assign msiCtrlWord = {{MSI_RSVD_W{1'b0}},
                        1'b0,
                        ADDR64_CAPABLE,
                        mme_q,
                        MSG_CAPABLE_CODE,
                        msiEn_q};
  assign msixCtrlWord = {msixEn_q, msixFmask_q, {MSIX_RSVD_W{1'b0}}, msixTableSize};

  // Mirror sources.
  assign prefetchLimit_d = rootPortMode ? prefetchLimitIn : '0;
  assign tcVcMap_d = {tcMapUpperIn, {TC_ENTRY_W{1'b0}}};
  assign busDev_d = programmedBusDevValid ? programmedBusDev : capturedBusDev;

  // Read decode; unmapped offsets read zero.
  assign rdMsi = cfgRdAddr == MSI_CTRL_OFFSET;
  assign rdMsix = cfgRdAddr == MSIX_CTRL_OFFSET;
  assign rdPm = cfgRdAddr == PMCSR_OFFSET;
  assign rdData_d = rdMsi ? {msiCtrlWord, {CTRL_HALF_LSB{1'b0}}} :
                    rdMsix ? {msixCtrlWord, {CTRL_HALF_LSB{1'b0}}} :
                    rdPm ? {pmControlIn, pmStatusIn} : '0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msiEn_q <= 1'b0;
      mme_q <= MME_RST;
      msixEn_q <= 1'b0;
      msixFmask_q <= 1'b0;
    end else begin
      msiEn_q <= msiEn_d;
      mme_q <= mme_d;
      msixEn_q <= msixEn_d;
      msixFmask_q <= msixFmask_d;
    end
  end

  // Every mirror is one flop stage behind its source, so the application sees a change one cycle later.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prefetch_limit_upper_q <= '0;
      pmCtrlStatus_q <= '0;
      msiCtrl_q <= '0;
      msixCtrl_q <= '0;
      tcVcMap_q <= '0;
      msiData_q <= '0;
      msiAddrLo_q <= '0;
      msiAddrHi_q <= '0;
      busDevNum_q <= '0;
      msiVectorsAllocated_q <= VEC_ONE;
    end else begin
      prefetch_limit_upper_q <= prefetchLimit_d;
      pmCtrlStatus_q <= {pmControlIn, pmStatusIn};
      msiCtrl_q <= msiCtrlWord;
      msixCtrl_q <= msixCtrlWord;
      tcVcMap_q <= tcVcMap_d;
      msiData_q <= msiDataIn;
      msiAddrLo_q <= msiAddrLoIn;
      msiAddrHi_q <= msiAddrHiIn;
      busDevNum_q <= busDev_d;
      msiVectorsAllocated_q <= vecCount(mme_q);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgRdData_q <= '0;
      cfgRdValid_q <= 1'b0;
    end else begin
      cfgRdData_q <= cfgRdEn ? rdData_d : cfgRdData_q;
      cfgRdValid_q <= cfgRdEn;
    end
  end

  msi_issue_gate issueGate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .msiEnable(msiEn_q),
    .msgEnableCode(mme_q),
    .issueReq(issueReq),
    .issueVector(issueVector),
    .issueGrant_q(issueGrant_q),
    .grantVector_q(grantVector_q),
    .issueRefused_q(issueRefused_q)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_pr_lim_mode: assert property (1'b1 |=> prefetch_limit_upper_q == ($past(rootPortMode) ? $past(prefetchLimitIn) : '0))
    else $error("Prefetch limit mirror wrong for mode");
  chk_pm_halves: assert property (1'b1 |=> pmCtrlStatus_q[CTRL_HALF_LSB +: PM_HALF_W] == $past(pmControlIn)
                                   && pmCtrlStatus_q[PM_HALF_W-1:0] == $past(pmStatusIn))
    else $error("Power management halves misplaced");
  chk_msix_enable: assert property (wrMsixHi |=> ##1 msixCtrl_q[MSIX_EN_BIT] == $past(ctrlWrWord[MSIX_EN_BIT], 2))
    else $error("MSI-X enable not mirrored in two cycles");
  chk_tc0_zero: assert property (tcVcMap_q[TC_ENTRY_W-1:0] == '0) else $error("Traffic class 0 entry not zero");
  chk_tc_groups: assert property (1'b1 |=> tcVcMap_q[TCVC_W-1:TC_ENTRY_W] == $past(tcMapUpperIn))
    else $error("Traffic class entries misplaced");
  chk_msi_data: assert property (1'b1 |=> msiData_q == $past(msiDataIn)) else $error("MSI data mirror stale");
  chk_busdev_sel: assert property (programmedBusDevValid |=> busDevNum_q == $past(programmedBusDev))
    else $error("Programmed bus/device not selected");
  chk_mask_cap_zero: assert property (!msiCtrl_q[MASKCAP_BIT]) else $error("Mask capability bit set");
  chk_addr64_bit: assert property (1'b1 |=> msiCtrl_q[ADDR64_BIT] == ADDR64_CAPABLE)
    else $error("Address width bit wrong");
  chk_mme_count: assert property (wrMsiLo && mmeLegal |=> ##1 msiVectorsAllocated_q == vecCount($past(mmeWr, 2)))
    else $error("Vector allocation does not follow write");
  chk_msi_enable: assert property (wrMsiLo |=> ##1 msiCtrl_q[MSI_EN_BIT] == $past(ctrlWrWord[MSI_EN_BIT], 2))
    else $error("MSI enable not mirrored in two cycles");
  chk_mmc_field: assert property (1'b1 |=> msiCtrl_q[MMC_LSB +: MME_W] == MSG_CAPABLE_CODE)
    else $error("Multiple message capable field wrong");
  chk_addr_halves: assert property (1'b1 |=> msiAddrLo_q == $past(msiAddrLoIn) && msiAddrHi_q == $past(msiAddrHiIn))
    else $error("MSI address halves stale");
  chk_rsvd_zero: assert property (msiCtrl_q[CTRL_W-1:MSI_RSVD_LSB] == '0 && !(cfgRdValid_q && $past(rdMsi)
                                  && cfgRdData_q[CTRL_HALF_LSB+MSI_RSVD_LSB +: MSI_RSVD_W] != '0))
    else $error("Reserved MSI control bits nonzero");
  chk_mirror_lat: assert property ($changed(msiDataIn) |=> msiData_q == $past(msiDataIn))
    else $error("Mirror missed one-cycle update");

  cov_msi_enable: cover property (wrMsiLo && ctrlWrWord[MSI_EN_BIT] ##2 msiCtrl_q[MSI_EN_BIT]);
  cov_mme_last: cover property (wrMsiLo && mmeWr == MME_LAST);
  cov_root_port: cover property (rootPortMode ##1 prefetch_limit_upper_q != '0);
  cov_read_msi: cover property (cfgRdEn && rdMsi ##1 cfgRdValid_q);
endmodule : cfg_space_mirror
`default_nettype wire

// ---- app_layer_model.sv ----
/*
  Application-side model: keeps its own per-vector MSI mask, pulses MSI issue requests
  and picks a virtual channel for a packet from the mirrored traffic-class map.
  Assumes the bench sets sendReq for one cycle at a falling edge of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module app_layer_model
  import cfg_mirror_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sendReq,
  input wire logic [VEC_IDX_W-1:0] sendVector,
  input wire logic [31:0] vectorMask,
  input wire logic [TCVC_W-1:0] tcVcMap,
  input wire logic [2:0] pktTc,
  output logic issueReq,
  output logic [VEC_IDX_W-1:0] issueVector,
  output logic [2:0] pktVc
);
  logic pend_q;
  logic [VEC_IDX_W-1:0] vec_q;
  assign pktVc = tcVcMap[pktTc*TC_ENTRY_W +: TC_ENTRY_W];
  // A masked vector never reaches the core, since the core has no mask of its own.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      vec_q <= 5'h00;
    end else begin
      pend_q <= sendReq && !vectorMask[sendVector];
      vec_q <= sendVector;
    end
  end
  // Outside a request the vector lines toggle so that a stale value is never trusted.
  always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      issueReq <= 1'b0;
      issueVector <= 5'h00;
    end else begin
      issueReq <= pend_q;
      issueVector <= pend_q ? vec_q : ~issueVector;
    end
  end
endmodule : app_layer_model
`default_nettype wire

// ---- cfg_space_mirror_bench.sv ----
/*
  Self-checking bench for cfg_space_mirror with the application-side model.
  Assumes the package, the design files and app_layer_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_space_mirror_bench;
  import cfg_mirror_pkg::*;
  logic ref_clk, rst_n, rootPortMode, cfgWrEn, cfgRdEn, programmedBusDevValid, sendReq, issueReq;
  logic issueGrant, issueRefused, cfgRdValid;
  logic [CFG_ADDR_W-1:0] cfgWrAddr, cfgRdAddr;
  logic [CFG_DATA_W-1:0] cfgWrData, cfgRdData;
  logic [CFG_BE_W-1:0] cfgWrBe;
  logic [PR_LIM_W-1:0] prefetchLimitIn, prefetchOut;
  logic [PM_HALF_W-1:0] pmControlIn, pmStatusIn;
  logic [MSIX_TSIZE_W-1:0] msixTableSize;
  logic [TCVC_W-TC_ENTRY_W-1:0] tcMapUpperIn;
  logic [MSI_DATA_W-1:0] msiDataIn, msiData;
  logic [ADDR_HALF_W-1:0] msiAddrLoIn, msiAddrHiIn, msiAddrLo, msiAddrHi;
  logic [BUSDEV_W-1:0] capturedBusDev, programmedBusDev, busDevNum;
  logic [VEC_IDX_W-1:0] issueVector, grantVector, sendVector;
  logic [PMCSR_W-1:0] pmCtrlStatus;
  logic [CTRL_W-1:0] msiCtrl, msixCtrl;
  logic [TCVC_W-1:0] tcVcMap;
  logic [VEC_CNT_W-1:0] vecAlloc;
  logic [31:0] vectorMask;
  logic [2:0] pktTc, pktVc;
  int failures, check_count, cycles;

  cfg_space_mirror DUT (.ref_clk(ref_clk), .rst_n(rst_n), .rootPortMode(rootPortMode), .cfgWrEn(cfgWrEn),
    .cfgWrAddr(cfgWrAddr), .cfgWrData(cfgWrData), .cfgWrBe(cfgWrBe), .cfgRdEn(cfgRdEn), .cfgRdAddr(cfgRdAddr),
    .prefetchLimitIn(prefetchLimitIn), .pmControlIn(pmControlIn), .pmStatusIn(pmStatusIn),
    .msixTableSize(msixTableSize), .tcMapUpperIn(tcMapUpperIn), .msiDataIn(msiDataIn),
    .msiAddrLoIn(msiAddrLoIn), .msiAddrHiIn(msiAddrHiIn), .capturedBusDev(capturedBusDev),
    .programmedBusDev(programmedBusDev), .programmedBusDevValid(programmedBusDevValid),
    .issueReq(issueReq), .issueVector(issueVector), .prefetch_limit_upper_q(prefetchOut),
    .pmCtrlStatus_q(pmCtrlStatus), .msiCtrl_q(msiCtrl), .msixCtrl_q(msixCtrl), .tcVcMap_q(tcVcMap),
    .msiData_q(msiData), .msiAddrLo_q(msiAddrLo), .msiAddrHi_q(msiAddrHi), .busDevNum_q(busDevNum),
    .msiVectorsAllocated_q(vecAlloc), .cfgRdData_q(cfgRdData), .cfgRdValid_q(cfgRdValid),
    .issueGrant_q(issueGrant), .grantVector_q(grantVector), .issueRefused_q(issueRefused));
  app_layer_model app (.ref_clk(ref_clk), .rst_n(rst_n), .sendReq(sendReq), .sendVector(sendVector),
    .vectorMask(vectorMask), .tcVcMap(tcVcMap), .pktTc(pktTc), .issueReq(issueReq),
    .issueVector(issueVector), .pktVc(pktVc));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("unexpected at %0t: run did not finish", $time);
      end_sim;
    end
  end

  task check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  // Effect of a write is looked at only after both internal stages have settled.
  task cfg_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    cfgWrEn = 1'b1; cfgWrAddr = a; cfgWrData = d; cfgWrBe = be;
    @(negedge ref_clk);
    cfgWrEn = 1'b0; cfgWrAddr = ~a; cfgWrData = ~d;
    repeat (2) @(negedge ref_clk);
  endtask : cfg_write

  task cfg_read(input logic [11:0] a, input logic [31:0] exp);
    int n;
    cfgRdEn = 1'b1; cfgRdAddr = a;
    @(negedge ref_clk);
    cfgRdEn = 1'b0; cfgRdAddr = ~a;
    n = 0;
    while (cfgRdValid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    check_val(cfgRdValid, 1, "read valid");
    check_val(cfgRdData, exp, "read data");
    @(negedge ref_clk);
  endtask : cfg_read

  task msi_issue(input logic [4:0] v, input logic expGrant, input logic expAnswer);
    int n;
    sendReq = 1'b1; sendVector = v;
    @(negedge ref_clk);
    sendReq = 1'b0;
    n = 0;
    while (issueGrant !== 1'b1 && issueRefused !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    check_val(issueGrant, expGrant & expAnswer, "grant");
    check_val(issueRefused, !expGrant & expAnswer, "refusal");
    if (expGrant) check_val(grantVector, v, "granted vector");
    @(negedge ref_clk);
  endtask : msi_issue

  task test_reset;
    check_val(vecAlloc, 6'h01, "vectors in reset");
    check_val(msiCtrl, 0, "msi control in reset");
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check_val(msiCtrl, 16'h008a, "msi control after reset");
    $display("test_reset finished");
  endtask : test_reset

  task test_mirrors;
    rootPortMode = 1'b1;
    repeat (2) @(negedge ref_clk);
    check_val(prefetchOut, prefetchLimitIn, "prefetch limit");
    check_val(pmCtrlStatus, {16'hc1a5, 16'h5e3c}, "power management");
    for (int tc = 0; tc < TC_COUNT; tc++) check_val(tcVcMap[tc*3 +: 3], tc, "tc map entry");
    check_val(msiData, 16'h3c96, "msi data");
    msiDataIn = 16'h69c3;
    @(negedge ref_clk);
    check_val(msiData, 16'h69c3, "msi data one cycle later");
    check_val({msiAddrHi, msiAddrLo}, 64'h9abc_def0_1234_5678, "msi address");
    check_val(busDevNum, 13'h0a5a, "captured bus/device");
    rootPortMode = 1'b0;
    programmedBusDevValid = 1'b1;
    repeat (2) @(negedge ref_clk);
    check_val(prefetchOut, 0, "prefetch limit endpoint");
    check_val(busDevNum, 13'h15a5, "programmed bus/device");
    $display("test_mirrors finished");
  endtask : test_mirrors

  task test_msi_ctrl;
    cfg_write(MSI_CTRL_OFFSET, 32'hffff_ffff, 4'hf);
    check_val(msiCtrl, 16'h008b, "msi control all ones");
    for (int c = 0; c < 6; c++) begin
      cfg_write(MSI_CTRL_OFFSET, 32'h0001_0000 | (32'(c) << 20), 4'h4);
      check_val(msiCtrl, 16'h008b | (16'(c) << 4), "msi enable field");
      check_val(vecAlloc, 6'h01 << c, "vectors allocated");
    end
    cfg_write(MSI_CTRL_OFFSET, 32'h0000_0000, 4'hb);
    check_val(msiCtrl, 16'h00db, "msi control lane off");
    cfg_read(MSI_CTRL_OFFSET, 32'h00db_0000);
    cfg_read(PMCSR_OFFSET, {16'hc1a5, 16'h5e3c});
    cfg_read(12'h100, 32'h0000_0000);
    $display("test_msi_ctrl finished");
  endtask : test_msi_ctrl

  task test_msix;
    cfg_write(MSIX_CTRL_OFFSET, 32'hffff_ffff, 4'h8);
    check_val(msixCtrl, {2'h3, 3'h0, 11'h2a5}, "msix control");
    cfg_write(MSIX_CTRL_OFFSET, 32'h0000_0000, 4'h4);
    check_val(msixCtrl, {2'h3, 3'h0, 11'h2a5}, "msix lane off");
    $display("test_msix finished");
  endtask : test_msix

  task test_issue;
    cfg_write(MSI_CTRL_OFFSET, 32'h0021_0000, 4'h4);
    msi_issue(5'h03, 1'b1, 1'b1);
    msi_issue(5'h04, 1'b0, 1'b1);
    vectorMask[1] = 1'b1;
    msi_issue(5'h01, 1'b0, 1'b0);
    cfg_write(MSI_CTRL_OFFSET, 32'h0020_0000, 4'h4);
    msi_issue(5'h00, 1'b0, 1'b1);
    for (int tc = 0; tc < TC_COUNT; tc++) begin
      pktTc = 3'(tc);
      #1;
      check_val(pktVc, tc, "virtual channel");
    end
    $display("test_issue finished");
  endtask : test_issue

  initial begin
    rst_n = 1'b0; rootPortMode = 1'b0; cfgWrEn = 1'b0; cfgRdEn = 1'b0; sendReq = 1'b0;
    cfgWrAddr = 12'h000; cfgRdAddr = 12'h000; cfgWrData = 32'h0; cfgWrBe = 4'h0;
    prefetchLimitIn = 44'h123_4567_89ab; pmControlIn = 16'hc1a5; pmStatusIn = 16'h5e3c;
    msixTableSize = 11'h2a5; tcMapUpperIn = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
    msiDataIn = 16'h3c96; msiAddrLoIn = 32'h1234_5678; msiAddrHiIn = 32'h9abc_def0;
    capturedBusDev = 13'h0a5a; programmedBusDev = 13'h15a5; programmedBusDevValid = 1'b0;
    sendVector = 5'h00; vectorMask = 32'h0; pktTc = 3'h0;
    repeat (3) @(negedge ref_clk);
    test_reset;
    test_mirrors;
    test_msi_ctrl;
    test_msix;
    test_issue;
    end_sim;
  end
endmodule : cfg_space_mirror_bench
`default_nettype wire
